// File: calib_eeprom_map_decoder_test.sv
// Self-checking testbench of the calibration map decoder.
`define CHK(name, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            badCount++; \
            $display("wrong value %s expected %h seen %h", name, exp, got); \
        end \
    end

module calib_eeprom_map_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Signals
    // =====================================================================
    logic mclk;
    logic rst_b;
    logic wrEn;
    logic [5:0] wrAddr;
    logic [7:0] wrData;
    logic [5:0] rdAddr;
    logic [7:0] rdData;
    logic [7:0] baseSum;
    logic checksumEnable;
    logic alarmModeSel;
    logic levelSteerSel;
    logic voltageModeSel;
    logic currentModeSel;
    logic pressureLayout;
    logic [7:0] sig [4];
    logic [9:0] internalTemp;
    logic [7:0] oscTrim;
    logic [7:0] tempAmpSetting;
    logic loaded;
    logic checksumFail;
    logic [9:0] faultOutput;
    cemd_pkg::cemd_coef_s coef;
    cemd_pkg::cemd_flag_s flags;
    logic [3:0] layoutTempco;
    logic [7:0] d;
    int badCount;
    int comparisons;

    cemd_host_model host (.mclk(mclk), .wrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData), .rdAddr(rdAddr), .rdData(rdData),
        .baseSum(baseSum));

    cemd_decoder dut (.mclk(mclk), .rst_b(rst_b), .wrEn(wrEn),
        .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr), .rdData(rdData),
        .baseSum(baseSum), .checksumEnable(checksumEnable),
        .alarmModeSel(alarmModeSel), .levelSteerSel(levelSteerSel),
        .voltageModeSel(voltageModeSel), .currentModeSel(currentModeSel),
        .pressureLayout(pressureLayout), .tempPathSig(sig[0]),
        .inputAmpSig(sig[1]), .gainStageSig(sig[2]),
        .voltageOutSig(sig[3]), .internalTemp(internalTemp),
        .oscTrim(oscTrim), .tempAmpSetting(tempAmpSetting),
        .loaded(loaded), .checksumFail(checksumFail),
        .faultOutput(faultOutput), .coef(coef), .flags(flags),
        .layoutTempco(layoutTempco));

    // =====================================================================
    // Clock, watchdog and helpers
    // =====================================================================
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        conclude();
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // Bytes reach the working registers only through this reload.
    task automatic resetDut;
        rst_b = 1'b0;
        tick(8);
        rst_b = 1'b1;
        for (int k = 0; k < 60 && loaded !== 1'b1; k++) begin
            tick(1);
        end
        `CHK("loaded", 1'b1, loaded);
    endtask : resetDut

    // The chosen input gets v, all others sit at a mid value.
    task automatic setSig(input int code, input logic [7:0] v);
        for (int i = 0; i < 4; i++) begin
            sig[i] = (i == code) ? v : 8'h60;
        end
    endtask : setSig

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // =====================================================================
    // Tests
    // =====================================================================
    initial begin
        logic [7:0] trims [4];
        logic [7:0] temps [4];
        logic [7:0] lvls [4];
        trims = '{8'h61, 8'h62, 8'h62, 8'h63};
        temps = '{8'h3F, 8'h40, 8'h7F, 8'h80};
        lvls = '{8'h20, 8'h40, 8'h60, 8'hA0};
        badCount = 0;
        comparisons = 0;
        rst_b = 1'b0;
        baseSum = 8'h10;
        checksumEnable = 1'b1;
        alarmModeSel = 1'b0;
        levelSteerSel = 1'b0;
        voltageModeSel = 1'b0;
        currentModeSel = 1'b0;
        pressureLayout = 1'b0;
        internalTemp = 10'h3FF;
        setSig(0, 8'h60);
        tick(1);
        resetDut();
        host.writeMap();
        tick(1);
        host.putByte(6'h05, 8'hFF);
        host.idleLines();
        resetDut();
        `CHK("fixedGainTop", 2'h2, coef.fixedGain[9:8]);
        `CHK("fixedOffsetTop", 2'h1, coef.fixedOffset[9:8]);
        `CHK("gainTcTop", 4'h9, coef.gainTempcoOne[11:8]);
        `CHK("offsetTcTop", 4'hC, coef.offsetTempcoOne[11:8]);
        `CHK("lowBytes", 32'h11223344, {coef.tc3OrPoint2Low,
            coef.tr3OrCoef2Low, coef.gtc4OrPoint1Low,
            coef.otc4OrCoef1Low});
        `CHK("packed", 36'h12345678B, {coef.packedA, coef.packedB,
            coef.packedC, coef.packedD, coef.packedEHigh});
        `CHK("ordinate", 10'h25A, coef.outputOrdinate);
        `CHK("gaps", 8'h53, {coef.lastPressurePoint,
            coef.lastTempPoint});
        `CHK("filter", 4'h7, coef.tempFilterCoef);
        `CHK("faultValue", 10'h37E, coef.faultValue);
        `CHK("ampGain", 8'h5C, tempAmpSetting);
        `CHK("checksumFail", 1'b0, checksumFail);
        `CHK("faultOutput", 10'h000, faultOutput);
        `CHK("layoutTempco", 4'hF, layoutTempco);
        pressureLayout = 1'b1;
        tick(1);
        `CHK("layoutPressure", 4'h0, layoutTempco);
        host.readByte(6'h18, d);
        `CHK("readGap", 8'h53, d);
        host.readByte(6'h05, d);
        `CHK("readBelow", 8'h00, d);
        host.readByte(6'h30, d);
        `CHK("readAbove", 8'h00, d);
        host.img[24] = 8'h42;
        host.writeMap();
        tick(2);
        `CHK("gapsHeld", 4'h3, coef.lastTempPoint);
        resetDut();
        `CHK("gapsNew", 8'h42, {coef.lastPressurePoint,
            coef.lastTempPoint});
        host.putByte(6'h2F, host.img[47] + 8'h01);
        host.idleLines();
        resetDut();
        `CHK("sumFail", 1'b1, checksumFail);
        `CHK("faultDriven", 10'h37E, faultOutput);
        checksumEnable = 1'b0;
        resetDut();
        `CHK("sumOff", 1'b0, checksumFail);
        for (int j = 0; j < 4; j++) begin
            internalTemp = {temps[j], 2'b11};
            resetDut();
            tick(3);
            `CHK("oscTrim", trims[j], oscTrim);
        end
        alarmModeSel = 1'b1;
        for (int c = 0; c < 4; c++) begin
            host.img[31] = {3'(c), 5'h0A};
            host.writeMap();
            resetDut();
            setSig(c, 8'h10);
            tick(3);
            `CHK("alarmLow", 1'b1, flags.alarmLow);
            `CHK("lowOut", 8'h55, flags.digitalOutputValue);
            setSig(c, 8'hC0);
            tick(3);
            `CHK("alarmHigh", 1'b1, flags.alarmHigh);
            `CHK("highOut", 8'hAA, flags.digitalOutputValue);
            `CHK("override", 1'b1, flags.digitalOverride);
        end
        // Code 4 watches the low level flag, which is low outside steering.
        host.img[31] = 8'h8A;
        host.writeMap();
        resetDut();
        tick(3);
        `CHK("alarmFlagIn", 1'b1, flags.alarmLow);
        voltageModeSel = 1'b1;
        currentModeSel = 1'b1;
        resetDut();
        setSig(3, 8'h10);
        tick(3);
        `CHK("alarmBothSel", 1'b0, flags.alarmLow);
        voltageModeSel = 1'b0;
        currentModeSel = 1'b0;
        levelSteerSel = 1'b1;
        for (int c = 0; c < 4; c++) begin
            alarmModeSel = c[0];
            host.img[31] = {2'(c), 6'h0A};
            host.writeMap();
            resetDut();
            for (int j = 0; j < 4; j++) begin
                setSig(c, lvls[j]);
                tick(3);
                `CHK("levels", 2'(j), {flags.levelFlagHigh,
                    flags.levelFlagLow});
                `CHK("alarmOff", 1'b0, flags.alarmLow);
            end
        end
        conclude();
    end
endmodule : calib_eeprom_map_decoder_test

// File: cemd_decoder.sv
// Calibration map store and decoder for map bytes 12 to 47.
`include "cemd_map.svh"

// Function
// - Wide coefficients join a low byte with a nibble or two bits of a shared packed byte.
// - Byte 17 upper nibble gives gain top bits, lower gives offset top bits.
// - Byte 18 upper nibble gives gain tempco bits 11:8, lower offset tempco.
// - Bytes 12-15 and 19-23 nibbles mean tempco or pressure data by layout.
// - Output ordinate is byte 16 plus two bits from byte 23 lower nibble.
// - Gap counts for the piecewise compensation come from byte 24.
// - Byte 25 low nibble is the filter coefficient; writer keeps top bits zero.
// - Alarm mode: input below byte 27 raises low alarm, output byte 28.
// - Alarm mode: input above byte 29 raises high alarm, output byte 30.
// - Steering mode: bytes 27-29 are ascending levels stepping flags 00 to 11.
// - Alarm mode: three bits of byte 31 select one of six inputs.
// - Steering mode: two bits of byte 31 select one of four inputs.
// - Byte 31 selection decodes by mode; its five low bits are ignored.
// - Alarm stays inactive when current and voltage mode selects are both set.
// - Oscillator trim comes from byte 32, 33 or 34 for cold, mid, hot.
// - Trim range uses the top eight temperature bits against bytes 35 and 36.
// - Byte 39 configures the temperature amplifier for the trim reading.
// - A failed checksum forces the output to the fault value of bytes 40-41.
// - Bytes 26, 37-38 and 42-46 only enter the checksum sum.
// - Gap byte upper nibble is last pressure point, lower last temperature.
// - With alarm and steering both set, steering runs and alarm is off.
// - Alarm input selection is the top three bits of byte 31.
// - With checksum test enabled, the sum is checked at each reset load.
module cemd_decoder (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire logic [5:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic [5:0] rdAddr,
    output logic [7:0] rdData,
    input wire logic [7:0] baseSum,
    input wire logic checksumEnable,
    input wire logic alarmModeSel,
    input wire logic levelSteerSel,
    input wire logic voltageModeSel,
    input wire logic currentModeSel,
    input wire logic pressureLayout,
    input wire logic [7:0] tempPathSig,
    input wire logic [7:0] inputAmpSig,
    input wire logic [7:0] gainStageSig,
    input wire logic [7:0] voltageOutSig,
    input wire logic [9:0] internalTemp,
    output logic [7:0] oscTrim,
    output logic [7:0] tempAmpSetting,
    output logic loaded,
    output logic checksumFail,
    output logic [9:0] faultOutput,
    output cemd_pkg::cemd_coef_s coef,
    output cemd_pkg::cemd_flag_s flags,
    output logic [3:0] layoutTempco
);

    // ========================================================
    // Nonvolatile byte array, written by the host link.
    logic [7:0] mem [0:`CEMD_NUM_BYTES-1];
    logic [5:0] wrIdx;
    logic [5:0] rdIdx;
    logic wrHit;

    always_comb begin
        wrIdx = wrAddr - `CEMD_FIRST_BYTE;
        rdIdx = rdAddr - `CEMD_FIRST_BYTE;
        wrHit = wrEn && wrAddr >= `CEMD_FIRST_BYTE &&
            wrAddr <= `CEMD_LAST_BYTE;
    end

    always_ff @(posedge mclk) begin
        if (wrHit) begin
            mem[wrIdx] <= wrData;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 8'h00;
        end else if (rdAddr >= `CEMD_FIRST_BYTE &&
            rdAddr <= `CEMD_LAST_BYTE) begin
            rdData <= mem[rdIdx];
        end else begin
            rdData <= 8'h00;
        end
    end

    function automatic logic [7:0] pick4(input logic [1:0] s,
        input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] c, input logic [7:0] d);
        case (s)
            2'h0: pick4 = a;
            2'h1: pick4 = b;
            2'h2: pick4 = c;
            default: pick4 = d;
        endcase
    endfunction : pick4

    // ========================================================
    // Load sequencer and decoding.
    cemd_pkg::cemd_st_s st;
    cemd_pkg::cemd_st_s next_st;
    logic [7:0] ld;
    logic [5:0] ldIdx;
    logic alarmActive;
    logic steerActive;
    logic [7:0] alarmIn;
    logic [7:0] steerIn;

    always_comb begin
        ldIdx = st.loadAddr - `CEMD_FIRST_BYTE;
        ld = mem[ldIdx];
    end

    always_comb begin
        steerActive = levelSteerSel;
        alarmActive = alarmModeSel && !levelSteerSel &&
            !(voltageModeSel && currentModeSel);
        // Low nibble of the control byte never reaches either selector.
        case (st.selByte[`CEMD_SEL_ALARM])
            3'h0: alarmIn = tempPathSig;
            3'h1: alarmIn = inputAmpSig;
            3'h2: alarmIn = gainStageSig;
            3'h3: alarmIn = voltageOutSig;
            3'h4: alarmIn = {7'h00, st.flag.levelFlagLow};
            default: alarmIn = {7'h00, st.flag.levelFlagHigh};
        endcase
        steerIn = pick4(st.selByte[`CEMD_SEL_STEER], tempPathSig,
            inputAmpSig, gainStageSig, voltageOutSig);
    end

    always_comb begin
        next_st = st;
        case (st.state)
            cemd_pkg::CEMD_IDLE: begin
                next_st.state = cemd_pkg::CEMD_LOAD;
                next_st.loadAddr = `CEMD_FIRST_BYTE;
                next_st.sum = baseSum;
            end
            cemd_pkg::CEMD_LOAD: begin
                next_st.sum = st.sum + ld;
                if (st.loadAddr == `CEMD_OFS_TC3L) begin
                    next_st.coef.tc3OrPoint2Low = ld;
                end else if (st.loadAddr == `CEMD_OFS_TR3L) begin
                    next_st.coef.tr3OrCoef2Low = ld;
                end else if (st.loadAddr == `CEMD_OFS_GTC4L) begin
                    next_st.coef.gtc4OrPoint1Low = ld;
                end else if (st.loadAddr == `CEMD_OFS_OTC4L) begin
                    next_st.coef.otc4OrCoef1Low = ld;
                end else if (st.loadAddr == `CEMD_OFS_ORDL) begin
                    next_st.coef.outputOrdinate[7:0] = ld;
                end else if (st.loadAddr == `CEMD_OFS_FIXHI) begin
                    next_st.coef.fixedGain[9:8] = ld[5:4];
                    next_st.coef.fixedOffset[9:8] = ld[1:0];
                end else if (st.loadAddr == `CEMD_OFS_TC1HI) begin
                    next_st.coef.gainTempcoOne[11:8] =
                        ld[`CEMD_HI_NIB];
                    next_st.coef.offsetTempcoOne[11:8] =
                        ld[`CEMD_LO_NIB];
                end else if (st.loadAddr == `CEMD_OFS_PKA) begin
                    next_st.coef.packedA = ld;
                end else if (st.loadAddr == `CEMD_OFS_PKB) begin
                    next_st.coef.packedB = ld;
                end else if (st.loadAddr == `CEMD_OFS_PKC) begin
                    next_st.coef.packedC = ld;
                end else if (st.loadAddr == `CEMD_OFS_PKD) begin
                    next_st.coef.packedD = ld;
                end else if (st.loadAddr == `CEMD_OFS_PKE) begin
                    next_st.coef.packedEHigh = ld[`CEMD_HI_NIB];
                    next_st.coef.outputOrdinate[9:8] = ld[1:0];
                end else if (st.loadAddr == `CEMD_OFS_GAP) begin
                    next_st.coef.lastPressurePoint =
                        ld[`CEMD_HI_NIB];
                    next_st.coef.lastTempPoint = ld[`CEMD_LO_NIB];
                end else if (st.loadAddr == `CEMD_OFS_FILT) begin
                    next_st.coef.tempFilterCoef = ld[`CEMD_LO_NIB];
                end else if (st.loadAddr == `CEMD_OFS_LVL1) begin
                    next_st.lvl1 = ld;
                end else if (st.loadAddr == `CEMD_OFS_LVL2) begin
                    next_st.lvl2 = ld;
                end else if (st.loadAddr == `CEMD_OFS_LVL3) begin
                    next_st.lvl3 = ld;
                end else if (st.loadAddr == `CEMD_OFS_AHOUT) begin
                    next_st.alarmHighOut = ld;
                end else if (st.loadAddr == `CEMD_OFS_SEL) begin
                    next_st.selByte = ld;
                end else if (st.loadAddr == `CEMD_OFS_TRIMC) begin
                    next_st.trimCold = ld;
                end else if (st.loadAddr == `CEMD_OFS_TRIMM) begin
                    next_st.trimMid = ld;
                end else if (st.loadAddr == `CEMD_OFS_TRIMH) begin
                    next_st.trimHot = ld;
                end else if (st.loadAddr == `CEMD_OFS_BNDA) begin
                    next_st.boundA = ld;
                end else if (st.loadAddr == `CEMD_OFS_BNDB) begin
                    next_st.boundB = ld;
                end else if (st.loadAddr == `CEMD_OFS_AMPG) begin
                    next_st.coef.ampGain = ld;
                end else if (st.loadAddr == `CEMD_OFS_FAULTL) begin
                    next_st.coef.faultValue[7:0] = ld;
                end else if (st.loadAddr == `CEMD_OFS_FAULTH) begin
                    next_st.coef.faultValue[9:8] = ld[1:0];
                end
                // Spare and user bytes only enter the sum.
                if (st.loadAddr == `CEMD_LAST_BYTE) begin
                    next_st.state = cemd_pkg::CEMD_RUN;
                    next_st.loaded = 1'b1;
                    next_st.checksumFail = checksumEnable &&
                        (st.sum + ld) != `CEMD_SUM_TARGET;
                end else begin
                    next_st.loadAddr = st.loadAddr + 6'h01;
                end
            end
            default: begin
                next_st.state = cemd_pkg::CEMD_RUN;
            end
        endcase

        // Range selection uses the top eight temperature bits.
        if (internalTemp[9:2] < st.boundA) begin
            next_st.oscTrim = st.trimCold;
        end else if (internalTemp[9:2] < st.boundB) begin
            next_st.oscTrim = st.trimMid;
        end else begin
            next_st.oscTrim = st.trimHot;
        end

        next_st.flag.alarmLow = alarmActive && st.loaded &&
            alarmIn < st.lvl1;
        next_st.flag.alarmHigh = alarmActive && st.loaded &&
            alarmIn > st.lvl3;
        if (next_st.flag.alarmLow) begin
            next_st.flag.digitalOutputValue = st.lvl2;
        end else if (next_st.flag.alarmHigh) begin
            next_st.flag.digitalOutputValue = st.alarmHighOut;
        end else begin
            next_st.flag.digitalOutputValue = 8'h00;
        end
        next_st.flag.digitalOverride = next_st.flag.alarmLow ||
            next_st.flag.alarmHigh;
        if (steerActive && st.loaded) begin
            {next_st.flag.levelFlagHigh, next_st.flag.levelFlagLow} =
                steerIn > st.lvl3 ? 2'h3 :
                steerIn > st.lvl2 ? 2'h2 :
                steerIn > st.lvl1 ? 2'h1 : 2'h0;
        end else begin
            next_st.flag.levelFlagHigh = 1'b0;
            next_st.flag.levelFlagLow = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.state <= cemd_pkg::CEMD_IDLE;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        oscTrim = st.oscTrim;
        tempAmpSetting = st.coef.ampGain;
        loaded = st.loaded;
        checksumFail = st.checksumFail;
        faultOutput = st.checksumFail ? st.coef.faultValue : 10'h000;
        coef = st.coef;
        flags = st.flag;
        layoutTempco = pressureLayout ? 4'h0 : 4'hF;
    end

    // ========================================================
    // Checks.
    sequence loadDone;
        st.state == cemd_pkg::CEMD_LOAD && st.loadAddr == `CEMD_LAST_BYTE;
    endsequence

    AST_LOAD_TIME: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(st.state == cemd_pkg::CEMD_LOAD) |-> ##35 loadDone ##1 loaded)
        else $error("load did not finish in 36 cycles");
    AST_FAULT: assert property (@(posedge mclk) disable iff (!rst_b)
        checksumFail |-> faultOutput == st.coef.faultValue)
        else $error("fault value not driven");
    AST_NO_CS: assert property (@(posedge mclk) disable iff (!rst_b)
        loadDone and !checksumEnable |=> !checksumFail)
        else $error("checksum failed while disabled");
    AST_ALARM_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(levelSteerSel || (voltageModeSel && currentModeSel))
        |-> !flags.alarmLow && !flags.alarmHigh)
        else $error("alarm active while blocked");
    AST_ALARM_LO: assert property (@(posedge mclk) disable iff (!rst_b)
        flags.alarmLow |-> flags.digitalOutputValue == st.lvl2)
        else $error("low alarm output wrong");
    AST_ALARM_HI: assert property (@(posedge mclk) disable iff (!rst_b)
        flags.alarmHigh && !flags.alarmLow
        |-> flags.digitalOutputValue == st.alarmHighOut)
        else $error("high alarm output wrong");
    AST_TRIM: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(internalTemp[9:2]) < $past(st.boundA) && $stable(st.trimCold)
        |-> oscTrim == st.trimCold)
        else $error("cold trim not selected");
    AST_STEER: assert property (@(posedge mclk) disable iff (!rst_b)
        !$past(levelSteerSel) |-> !flags.levelFlagLow && !flags.levelFlagHigh)
        else $error("level flags set outside steering");
endmodule : cemd_decoder

// File: cemd_host_model.sv
// Host calibration station model that writes and reads the map bytes.
module cemd_host_model (
    input wire logic mclk,
    output logic wrEn,
    output logic [5:0] wrAddr,
    output logic [7:0] wrData,
    output logic [5:0] rdAddr,
    input wire logic [7:0] rdData,
    input wire logic [7:0] baseSum
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Map image
    // =====================================================================
    logic [7:0] img [12:47];

    initial begin
        wrEn = 1'b0;
        wrAddr = 6'h00;
        wrData = 8'h00;
        rdAddr = 6'h00;
        img = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h5A, 8'h21, 8'h9C, 8'h12,
                8'h34, 8'h56, 8'h78, 8'hB2, 8'h53, 8'hF7, 8'hEE, 8'h30,
                8'h55, 8'h90, 8'hAA, 8'h0A, 8'h61, 8'h62, 8'h63, 8'h40,
                8'h80, 8'hD1, 8'hD2, 8'h5C, 8'h7E, 8'h03, 8'hE0, 8'hE1,
                8'hE2, 8'hE3, 8'hE4, 8'h00};
    end

    // =====================================================================
    // Link tasks
    // =====================================================================
    // The strobe stays high so that consecutive bytes go back to back.
    task automatic putByte(input logic [5:0] a, input logic [7:0] d);
        wrEn = 1'b1;
        wrAddr = a;
        wrData = d;
        @(posedge mclk);
        #1;
    endtask : putByte

    // Released lines show the inverse so stale values are never reused.
    task automatic idleLines;
        wrEn = 1'b0;
        wrAddr = ~wrAddr;
        wrData = ~wrData;
    endtask : idleLines

    task automatic readByte(input logic [5:0] a, output logic [7:0] d);
        rdAddr = a;
        @(posedge mclk);
        #1;
        d = rdData;
        rdAddr = ~a;
        @(posedge mclk);
        #1;
    endtask : readByte

    task automatic writeMap;
        logic [7:0] s;
        img[25] = img[25] & 8'h0F;
        s = baseSum;
        for (int i = 12; i < 47; i++) begin
            s = s + img[i];
        end
        img[47] = 8'hFF - s;
        for (int i = 12; i < 48; i++) begin
            putByte(6'(i), img[i]);
        end
        idleLines();
    endtask : writeMap
endmodule : cemd_host_model

// File: cemd_map.svh
// Byte offsets, field positions and sizes of the calibration map decoder.
`ifndef CEMD_MAP_SVH
`define CEMD_MAP_SVH
`define CEMD_FIRST_BYTE 6'h0C
`define CEMD_LAST_BYTE 6'h2F
`define CEMD_NUM_BYTES 36
`define CEMD_OFS_TC3L 6'h0C
`define CEMD_OFS_TR3L 6'h0D
`define CEMD_OFS_GTC4L 6'h0E
`define CEMD_OFS_OTC4L 6'h0F
`define CEMD_OFS_ORDL 6'h10
`define CEMD_OFS_FIXHI 6'h11
`define CEMD_OFS_TC1HI 6'h12
`define CEMD_OFS_PKA 6'h13
`define CEMD_OFS_PKB 6'h14
`define CEMD_OFS_PKC 6'h15
`define CEMD_OFS_PKD 6'h16
`define CEMD_OFS_PKE 6'h17
`define CEMD_OFS_GAP 6'h18
`define CEMD_OFS_FILT 6'h19
`define CEMD_OFS_SPARE 6'h1A
`define CEMD_OFS_LVL1 6'h1B
`define CEMD_OFS_LVL2 6'h1C
`define CEMD_OFS_LVL3 6'h1D
`define CEMD_OFS_AHOUT 6'h1E
`define CEMD_OFS_SEL 6'h1F
`define CEMD_OFS_TRIMC 6'h20
`define CEMD_OFS_TRIMM 6'h21
`define CEMD_OFS_TRIMH 6'h22
`define CEMD_OFS_BNDA 6'h23
`define CEMD_OFS_BNDB 6'h24
`define CEMD_OFS_AMPG 6'h27
`define CEMD_OFS_FAULTL 6'h28
`define CEMD_OFS_FAULTH 6'h29
`define CEMD_OFS_CSUM 6'h2F
`define CEMD_SUM_TARGET 8'hFF
`define CEMD_HI_NIB 7:4
`define CEMD_LO_NIB 3:0
`define CEMD_SEL_ALARM 7:5
`define CEMD_SEL_STEER 7:6
`endif

// File: cemd_pkg.sv
// Types shared by the calibration map decoder.
package cemd_pkg;
    typedef enum logic [2:0] {
        CEMD_IDLE = 3'b001,
        CEMD_LOAD = 3'b010,
        CEMD_RUN = 3'b100
    } cemd_state_e;

    typedef struct packed {
        logic [9:0] fixedGain;
        logic [9:0] fixedOffset;
        logic [11:0] gainTempcoOne;
        logic [11:0] offsetTempcoOne;
        logic [7:0] tc3OrPoint2Low;
        logic [7:0] tr3OrCoef2Low;
        logic [7:0] gtc4OrPoint1Low;
        logic [7:0] otc4OrCoef1Low;
        logic [7:0] packedA;
        logic [7:0] packedB;
        logic [7:0] packedC;
        logic [7:0] packedD;
        logic [3:0] packedEHigh;
        logic [9:0] outputOrdinate;
        logic [3:0] lastPressurePoint;
        logic [3:0] lastTempPoint;
        logic [3:0] tempFilterCoef;
        logic [9:0] faultValue;
        logic [7:0] ampGain;
    } cemd_coef_s;

    typedef struct packed {
        logic levelFlagLow;
        logic levelFlagHigh;
        logic alarmLow;
        logic alarmHigh;
        logic [7:0] digitalOutputValue;
        logic digitalOverride;
    } cemd_flag_s;

    typedef struct packed {
        cemd_state_e state;
        logic [5:0] loadAddr;
        logic [7:0] sum;
        logic [7:0] lvl1;
        logic [7:0] lvl2;
        logic [7:0] lvl3;
        logic [7:0] alarmHighOut;
        logic [7:0] selByte;
        logic [7:0] trimCold;
        logic [7:0] trimMid;
        logic [7:0] trimHot;
        logic [7:0] boundA;
        logic [7:0] boundB;
        logic [7:0] oscTrim;
        logic checksumFail;
        logic loaded;
        cemd_coef_s coef;
        cemd_flag_s flag;
    } cemd_st_s;
endpackage : cemd_pkg
